// file: logic/scs_pkg.sv
`default_nettype none
package scs_pkg;
    // ****************************************
    // Widths and storage
    // ****************************************
    localparam int unsigned WORD_W    = 18;
    localparam int unsigned MEM_WORDS = 64;
    localparam int unsigned STK_DEPTH = 8;
    localparam int unsigned PC_W      = 10;
    localparam int unsigned MADDR_W   = 9;

    // ****************************************
    // Address fields and reset values
    // ****************************************
    localparam int unsigned IO_SPACE_BIT  = 8;
    localparam int unsigned ROM_SPACE_BIT = 7;
    localparam int unsigned EXT_MATH_BIT  = 9;
    localparam logic [9:0]  P_RST         = 10'h0AA;
    localparam logic [8:0]  IO_CTRL_ADDR  = 9'h104;
    localparam logic [17:0] IO_RST        = 18'h15555;
    localparam logic [11:0] ROM_FILL      = 12'hC3A;
    localparam logic [2:0]  PTR_RST       = 3'h0;

    // ****************************************
    // Bus register byte offsets
    // ****************************************
    localparam logic [11:0] OFS_T      = 12'h000;
    localparam logic [11:0] OFS_S      = 12'h004;
    localparam logic [11:0] OFS_R      = 12'h008;
    localparam logic [11:0] OFS_A      = 12'h00C;
    localparam logic [11:0] OFS_B      = 12'h010;
    localparam logic [11:0] OFS_P      = 12'h014;
    localparam logic [11:0] OFS_I      = 12'h018;
    localparam logic [11:0] OFS_IO     = 12'h01C;
    localparam logic [11:0] OFS_CMD    = 12'h020;
    localparam logic [11:0] OFS_STAT   = 12'h024;
    localparam logic [3:0]  RAM_WIN_HI = 4'h1;

    typedef enum logic [3:0] {
        CMD_NOP    = 4'h0,
        CMD_DUP    = 4'h1,
        CMD_DROP   = 4'h2,
        CMD_RPUSH  = 4'h3,
        CMD_RPOP   = 4'h4,
        CMD_ADD    = 4'h5,
        CMD_MSTEP  = 4'h6,
        CMD_NOT    = 4'h7,
        CMD_LOOP   = 4'h8,
        CMD_FETCHP = 4'h9,
        CMD_FETCHA = 4'hA,
        CMD_STOREA = 4'hB
    } scs_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WR   = 2'b01,
        ST_RDW  = 2'b11,
        ST_RD   = 2'b10
    } scs_state_t;
endpackage : scs_pkg
`default_nettype wire

// file: logic/scs_core.sv
// Operation
// - RAM and ROM, 64 words of 18 bits
// - Data registers and paths are 18 bits wide; P is 10 bits, B is 9
// - Return buffer: 8 circular entries, overwrite oldest
// - Loop register sits above return buffer
// - Loop register decrements toward zero
// - Program counter increments after each fetch
// - No increment inside I/O region
// - Bit 9 enables extended arithmetic
// - Memory decode ignores bit 9
// - Address register readable, writable, address or data
// - Data stack: top, second, 8 circular
// - ALU uses top, second, address; carry latch
// - Instruction register takes fetched words
// - Reset loads configured start address
// - Reset sets I/O control as 15555 written
// - Reset fixes both stack pointers
// - Reset leaves data registers and RAM alone
// - Nine-bit addresses decode RAM, ROM, I/O
// - Increment 3F to 40, wraps 7F to 00
// - Increment never alters bits 8 or 9
// - Push: second into buffer, top into second
// - Pop: buffer into second, second into top
`timescale 1ns/1ps
`default_nettype none
module scs_core #(
    parameter logic [9:0] P_START = scs_pkg::P_RST
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             extended_math_enable
);
    // ****************************************
    // Bus slave
    // ****************************************
    scs_pkg::scs_state_t st_r;
    scs_pkg::scs_state_t st_nxt;
    logic [11:0] addr_r;
    logic [31:0] hrdata_r;
    logic        hreadyout_r;
    logic [17:0] rd_mux;

    wire acc    = hsel && htrans[1] && hready;
    wire bus_wr = (st_r == scs_pkg::ST_WR);
    wire hit_t  = (addr_r == scs_pkg::OFS_T);
    wire hit_s  = (addr_r == scs_pkg::OFS_S);
    wire hit_r  = (addr_r == scs_pkg::OFS_R);
    wire hit_a  = (addr_r == scs_pkg::OFS_A);
    wire hit_b  = (addr_r == scs_pkg::OFS_B);
    wire hit_p  = (addr_r == scs_pkg::OFS_P);
    wire hit_i  = (addr_r == scs_pkg::OFS_I);
    wire hit_io = (addr_r == scs_pkg::OFS_IO);
    wire hit_c  = (addr_r == scs_pkg::OFS_CMD);
    wire hit_st = (addr_r == scs_pkg::OFS_STAT);
    wire hit_m  = (addr_r[11:8] == scs_pkg::RAM_WIN_HI);
    wire cmd_go = bus_wr && hit_c;
    wire [3:0] cmd_raw = hwdata[3:0];
    scs_pkg::scs_cmd_t cmd;
    assign cmd = scs_pkg::scs_cmd_t'(cmd_raw);

    always_comb begin
        st_nxt = scs_pkg::ST_IDLE;
        if (acc && hwrite) begin
            st_nxt = scs_pkg::ST_WR;
        end else if (acc) begin
            st_nxt = scs_pkg::ST_RDW;
        end else if (st_r == scs_pkg::ST_RDW) begin
            st_nxt = scs_pkg::ST_RD;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r        <= scs_pkg::ST_IDLE;
            addr_r      <= 12'h000;
            hreadyout_r <= 1'b1;
            hrdata_r    <= 32'h0000_0000;
        end else begin
            st_r        <= st_nxt;
            hreadyout_r <= (st_nxt != scs_pkg::ST_RDW);
            if (acc) begin
                addr_r <= haddr[11:0];
            end
            if (st_r == scs_pkg::ST_RDW) begin
                hrdata_r <= {14'h0000, rd_mux};
            end
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp     = 1'b0;

    // ****************************************
    // Architectural state
    // ****************************************
    logic [17:0] t_r, s_r, r_r, a_r, i_r, io_r;
    logic [17:0] t_nxt, s_nxt, r_nxt, a_nxt, i_nxt, io_nxt;
    logic [9:0]  p_r, p_nxt;
    logic [8:0]  b_r, b_nxt;
    logic        c_r, c_nxt;
    logic [2:0]  dsp_r, dsp_nxt, rsp_r, rsp_nxt;
    logic [17:0] dstk [scs_pkg::STK_DEPTH];
    logic [17:0] rstk [scs_pkg::STK_DEPTH];
    logic [17:0] ram  [scs_pkg::MEM_WORDS];
    logic        d_push, d_pop, r_push, r_pop, ram_we;
    logic [5:0]  ram_idx;
    logic [17:0] ram_wd;

    assign extended_math_enable = p_r[scs_pkg::EXT_MATH_BIT];

    wire [2:0]  dsp_up = dsp_r + 3'h1;
    wire [2:0]  dsp_dn = dsp_r - 3'h1;
    wire [2:0]  rsp_up = rsp_r + 3'h1;
    wire [2:0]  rsp_dn = rsp_r - 3'h1;
    wire [17:0] dtop   = dstk[dsp_r];
    wire [17:0] rtop   = rstk[rsp_r];
    wire        cin    = extended_math_enable && c_r;
    wire [18:0] add19  = {1'b0, s_r} + {1'b0, t_r} + {18'h0, cin};
    wire [18:0] ms19   = {s_r[17], s_r} + {t_r[17], t_r} + {18'h0, cin};
    wire [18:0] cy19   = {1'b0, s_r} + {1'b0, t_r} + {18'h0, cin};

    // Low seven bits step; bits 7..9 are kept
    function automatic logic [9:0] addr_inc(input logic [9:0] x);
        if (x[scs_pkg::IO_SPACE_BIT]) begin
            addr_inc = x;
        end else begin
            addr_inc = {x[9:7], x[6:0] + 7'h01};
        end
    endfunction : addr_inc

    // Nine-bit decode; bit 9 never reaches here
    function automatic logic [17:0] mem_rd(input logic [8:0] x);
        if (x[scs_pkg::IO_SPACE_BIT]) begin
            mem_rd = (x == scs_pkg::IO_CTRL_ADDR) ? io_r : 18'h00000;
        end else if (x[scs_pkg::ROM_SPACE_BIT]) begin
            mem_rd = {scs_pkg::ROM_FILL, x[5:0]};
        end else begin
            mem_rd = ram[x[5:0]];
        end
    endfunction : mem_rd

    always_comb begin
        t_nxt   = t_r;
        s_nxt   = s_r;
        r_nxt   = r_r;
        a_nxt   = a_r;
        i_nxt   = i_r;
        io_nxt  = io_r;
        p_nxt   = p_r;
        b_nxt   = b_r;
        c_nxt   = c_r;
        d_push  = 1'b0;
        d_pop   = 1'b0;
        r_push  = 1'b0;
        r_pop   = 1'b0;
        ram_we  = 1'b0;
        ram_idx = addr_r[7:2];
        ram_wd  = hwdata[17:0];
        if (bus_wr) begin
            if (hit_t) begin
                t_nxt = hwdata[17:0];
            end else if (hit_s) begin
                s_nxt = hwdata[17:0];
            end else if (hit_r) begin
                r_nxt = hwdata[17:0];
            end else if (hit_a) begin
                a_nxt = hwdata[17:0];
            end else if (hit_b) begin
                b_nxt = hwdata[8:0];
            end else if (hit_p) begin
                p_nxt = hwdata[9:0];
            end else if (hit_io) begin
                io_nxt = hwdata[17:0];
            end else if (hit_st) begin
                // Carry latch loadable, never reset
                c_nxt = hwdata[1];
            end else if (hit_m) begin
                ram_we = 1'b1;
            end
        end
        if (cmd_go) begin
            case (cmd)
                scs_pkg::CMD_DUP: begin
                    d_push = 1'b1;
                    s_nxt  = t_r;
                end
                scs_pkg::CMD_DROP: begin
                    d_pop = 1'b1;
                    t_nxt = s_r;
                    s_nxt = dtop;
                end
                scs_pkg::CMD_RPUSH: begin
                    r_push = 1'b1;
                    r_nxt  = t_r;
                    d_pop  = 1'b1;
                    t_nxt  = s_r;
                    s_nxt  = dtop;
                end
                scs_pkg::CMD_RPOP: begin
                    r_pop  = 1'b1;
                    r_nxt  = rtop;
                    d_push = 1'b1;
                    s_nxt  = t_r;
                    t_nxt  = r_r;
                end
                scs_pkg::CMD_ADD: begin
                    t_nxt = add19[17:0];
                    d_pop = 1'b1;
                    s_nxt = dtop;
                    if (extended_math_enable) begin
                        c_nxt = add19[18];
                    end
                end
                scs_pkg::CMD_MSTEP: begin
                    if (!a_r[0]) begin
                        t_nxt = {t_r[17], t_r[17:1]};
                        a_nxt = {t_r[0], a_r[17:1]};
                    end else begin
                        t_nxt = ms19[18:1];
                        a_nxt = {ms19[0], a_r[17:1]};
                        if (extended_math_enable) begin
                            c_nxt = cy19[18];
                        end
                    end
                end
                scs_pkg::CMD_NOT: begin
                    t_nxt = ~t_r;
                end
                scs_pkg::CMD_LOOP: begin
                    if (r_r != 18'h00000) begin
                        r_nxt = r_r - 18'h00001;
                    end
                end
                scs_pkg::CMD_FETCHP: begin
                    i_nxt = mem_rd(p_r[8:0]);
                    p_nxt = addr_inc(p_r);
                end
                scs_pkg::CMD_FETCHA: begin
                    d_push = 1'b1;
                    s_nxt  = t_r;
                    t_nxt  = mem_rd(a_r[8:0]);
                    a_nxt  = {a_r[17:10], addr_inc(a_r[9:0])};
                end
                scs_pkg::CMD_STOREA: begin
                    if (a_r[8:0] == scs_pkg::IO_CTRL_ADDR) begin
                        io_nxt = t_r;
                    end else if (!a_r[8] && !a_r[7]) begin
                        ram_we  = 1'b1;
                        ram_idx = a_r[5:0];
                        ram_wd  = t_r;
                    end
                    d_pop = 1'b1;
                    t_nxt = s_r;
                    s_nxt = dtop;
                    a_nxt = {a_r[17:10], addr_inc(a_r[9:0])};
                end
                default: begin
                    t_nxt = t_r;
                end
            endcase
        end
    end

    assign dsp_nxt = d_push ? dsp_up : (d_pop ? dsp_dn : dsp_r);
    assign rsp_nxt = r_push ? rsp_up : (r_pop ? rsp_dn : rsp_r);

    // Unreset state keeps its contents across reset
    always_ff @(posedge hclk) begin
        t_r <= t_nxt;
        s_r <= s_nxt;
        r_r <= r_nxt;
        a_r <= a_nxt;
        i_r <= i_nxt;
        c_r <= c_nxt;
        if (d_push) begin
            dstk[dsp_up] <= s_r;
        end
        if (r_push) begin
            rstk[rsp_up] <= r_r;
        end
        if (ram_we) begin
            ram[ram_idx] <= ram_wd;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            p_r   <= P_START;
            io_r  <= scs_pkg::IO_RST;
            b_r   <= scs_pkg::IO_CTRL_ADDR;
            dsp_r <= scs_pkg::PTR_RST;
            rsp_r <= scs_pkg::PTR_RST;
        end else begin
            p_r   <= p_nxt;
            io_r  <= io_nxt;
            b_r   <= b_nxt;
            dsp_r <= dsp_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    always_comb begin
        rd_mux = 18'h00000;
        if (hit_t) begin
            rd_mux = t_r;
        end else if (hit_s) begin
            rd_mux = s_r;
        end else if (hit_r) begin
            rd_mux = r_r;
        end else if (hit_a) begin
            rd_mux = a_r;
        end else if (hit_p) begin
            rd_mux = {8'h00, p_r};
        end else if (hit_i) begin
            rd_mux = i_r;
        end else if (hit_io) begin
            rd_mux = io_r;
        end else if (hit_st) begin
            rd_mux = {10'h000, dsp_r, rsp_r, c_r, extended_math_enable};
        end else if (hit_m) begin
            rd_mux = ram[addr_r[7:2]];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    wire do_fp = cmd_go && (cmd == scs_pkg::CMD_FETCHP);

    AST_RST_REGS: assert property (@(posedge hclk)
        !hresetn |-> p_r == P_START && b_r == scs_pkg::IO_CTRL_ADDR
                     && io_r == scs_pkg::IO_RST)
        else $error("reset values wrong");
    AST_RST_PTRS: assert property (@(posedge hclk)
        !hresetn |-> dsp_r == 3'h0 && rsp_r == 3'h0)
        else $error("stack pointers not reset");
    AST_P_INC: assert property (@(posedge hclk)
        disable iff (!hresetn)
        do_fp && !p_r[8] |=> p_r[6:0] == $past(p_r[6:0]) + 7'h01
                             && p_r[9:7] == $past(p_r[9:7]))
        else $error("pc increment wrong");
    AST_P_IO: assert property (@(posedge hclk)
        disable iff (!hresetn)
        do_fp && p_r[8] |=> $stable(p_r))
        else $error("pc moved in io space");
    AST_P_WRAP: assert property (@(posedge hclk)
        disable iff (!hresetn)
        do_fp && !p_r[8] && p_r[6:0] == 7'h7F |=> p_r[6:0] == 7'h00)
        else $error("pc wrap wrong");
    AST_D_PUSH: assert property (@(posedge hclk)
        disable iff (!hresetn)
        cmd_go && cmd == scs_pkg::CMD_DUP |=> s_r == $past(t_r)
                     && dsp_r == $past(dsp_r) + 3'h1)
        else $error("data push wrong");
    AST_D_POP: assert property (@(posedge hclk)
        disable iff (!hresetn)
        cmd_go && cmd == scs_pkg::CMD_DROP |=> t_r == $past(s_r)
                     && dsp_r == $past(dsp_r) - 3'h1)
        else $error("data pop wrong");
    AST_R_PUSH: assert property (@(posedge hclk)
        disable iff (!hresetn)
        cmd_go && cmd == scs_pkg::CMD_RPUSH |=> r_r == $past(t_r)
                     && rsp_r == $past(rsp_r) + 3'h1)
        else $error("return push wrong");
    AST_LOOP: assert property (@(posedge hclk)
        disable iff (!hresetn)
        cmd_go && cmd == scs_pkg::CMD_LOOP && r_r != 18'h00000
        |=> r_r == $past(r_r) - 18'h00001)
        else $error("loop count wrong");
    AST_BUS_RD: assert property (@(posedge hclk)
        disable iff (!hresetn)
        acc && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
endmodule : scs_core
`default_nettype wire

// file: sim/tb_scs_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_scs_core;
    // ****************************************
    // Bus signals and bookkeeping
    // ****************************************
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        extended_math_enable;
    int          n_mismatch;
    int          num_checks;
    logic [31:0] rd;
    logic [17:0] rom_w;

    scs_core uut (
        .hclk                 (hclk),
        .hresetn              (hresetn),
        .hsel                 (hsel),
        .haddr                (haddr),
        .htrans               (htrans),
        .hwrite               (hwrite),
        .hsize                (hsize),
        .hwdata               (hwdata),
        .hready               (hreadyout),
        .hrdata               (hrdata),
        .hreadyout            (hreadyout),
        .hresp                (hresp),
        .extended_math_enable (extended_math_enable)
    );

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task give_verdict;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] hready expected 1 seen %b", hreadyout);
            give_verdict();
        end
    endtask : wait_rdy

    task bus(input logic wr, input logic [11:0] ofs, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {20'h0, ofs};
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask : bus

    task wr(input logic [11:0] ofs, input logic [31:0] d);
        bus(1'b1, ofs, d);
    endtask : wr

    task rchk(input string nm, input logic [11:0] ofs, input logic [31:0] e);
        bus(1'b0, ofs, 32'h0);
        chk(nm, rd, e);
    endtask : rchk

    task cmd(input scs_pkg::scs_cmd_t c);
        wr(scs_pkg::OFS_CMD, {28'h0, c});
    endtask : cmd

    task stat_chk(input logic [31:0] e);
        bus(1'b0, scs_pkg::OFS_STAT, 32'h0);
        chk("stat", rd & 32'hFD, e);
    endtask : stat_chk

    task do_reset;
        hresetn <= 1'b0;
        hsel    <= 1'b0;
        htrans  <= 2'b00;
        repeat (6) @(posedge hclk);
        chk("rdy_rst", {31'h0, hreadyout}, 32'h1);
        chk("ext_rst", {31'h0, extended_math_enable}, 32'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask : do_reset

    task fp(input logic [9:0] p, input logic [9:0] np, input logic [17:0] iw);
        wr(scs_pkg::OFS_P, {22'h0, p});
        cmd(scs_pkg::CMD_FETCHP);
        rchk("pc", scs_pkg::OFS_P, {22'h0, np});
        rchk("ir", scs_pkg::OFS_I, {14'h0, iw});
    endtask : fp

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset_vals;
        rchk("pc", scs_pkg::OFS_P, 32'h0AA);
        rchk("io", scs_pkg::OFS_IO, 32'h15555);
        stat_chk(32'h0);
        rchk("b", scs_pkg::OFS_B, 32'h0);
        rchk("unmapped", 12'h030, 32'h0);
        wr(12'h028, 32'h1234);
        rchk("unmapped", 12'h028, 32'h0);
    endtask : t_reset_vals

    task t_fetch;
        rom_w = {scs_pkg::ROM_FILL, 6'h3F};
        wr(12'h1FC, 32'h2ABCD);
        rchk("ram", 12'h1FC, 32'h2ABCD);
        wr(scs_pkg::OFS_T, 32'hFFFFFFFF);
        rchk("t", scs_pkg::OFS_T, 32'h3FFFF);
        fp(10'h03F, 10'h040, 18'h2ABCD);
        fp(10'h07F, 10'h000, 18'h2ABCD);
        fp(10'h0FF, 10'h080, rom_w);
        fp(10'h104, 10'h104, 18'h15555);
        fp(10'h1A0, 10'h1A0, 18'h0);
        fp(10'h27F, 10'h200, 18'h2ABCD);
        chk("ext", {31'h0, extended_math_enable}, 32'h1);
        wr(scs_pkg::OFS_I, 32'h11111);
        rchk("ir", scs_pkg::OFS_I, 32'h2ABCD);
    endtask : t_fetch

    task t_addr_a;
        wr(scs_pkg::OFS_A, 32'h3FFFF);
        rchk("a", scs_pkg::OFS_A, 32'h3FFFF);
        wr(scs_pkg::OFS_A, 32'h03F);
        wr(scs_pkg::OFS_T, 32'h12345);
        cmd(scs_pkg::CMD_STOREA);
        rchk("a", scs_pkg::OFS_A, 32'h040);
        rchk("ram", 12'h1FC, 32'h12345);
        wr(scs_pkg::OFS_A, 32'h07F);
        cmd(scs_pkg::CMD_FETCHA);
        rchk("t", scs_pkg::OFS_T, 32'h12345);
        rchk("a", scs_pkg::OFS_A, 32'h000);
        wr(scs_pkg::OFS_A, 32'h104);
        cmd(scs_pkg::CMD_FETCHA);
        rchk("a", scs_pkg::OFS_A, 32'h104);
    endtask : t_addr_a

    task t_stacks;
        for (int i = 1; i <= 10; i++) begin
            wr(scs_pkg::OFS_T, i);
            cmd(scs_pkg::CMD_DUP);
        end
        rchk("s", scs_pkg::OFS_S, 32'd10);
        for (int k = 9; k >= 2; k--) begin
            cmd(scs_pkg::CMD_DROP);
            rchk("s", scs_pkg::OFS_S, k);
        end
        cmd(scs_pkg::CMD_DROP);
        rchk("s", scs_pkg::OFS_S, 32'd9);
        for (int i = 1; i <= 9; i++) begin
            wr(scs_pkg::OFS_T, 32'h100 + i);
            cmd(scs_pkg::CMD_RPUSH);
        end
        rchk("r", scs_pkg::OFS_R, 32'h109);
        for (int k = 9; k >= 1; k--) begin
            cmd(scs_pkg::CMD_RPOP);
            rchk("t", scs_pkg::OFS_T, 32'h100 + k);
        end
        cmd(scs_pkg::CMD_RPOP);
        rchk("t", scs_pkg::OFS_T, 32'h108);
    endtask : t_stacks

    task t_alu;
        wr(scs_pkg::OFS_R, 32'h2);
        for (int k = 1; k >= 0; k--) begin
            cmd(scs_pkg::CMD_LOOP);
            rchk("r", scs_pkg::OFS_R, k);
        end
        cmd(scs_pkg::CMD_LOOP);
        rchk("r", scs_pkg::OFS_R, 32'h0);
        wr(scs_pkg::OFS_T, 32'h00F0F);
        cmd(scs_pkg::CMD_NOT);
        rchk("t", scs_pkg::OFS_T, 32'h3F0F0);
        wr(scs_pkg::OFS_P, 32'h000);
        wr(scs_pkg::OFS_S, 32'h1);
        wr(scs_pkg::OFS_T, 32'h3FFFF);
        cmd(scs_pkg::CMD_ADD);
        rchk("t", scs_pkg::OFS_T, 32'h0);
        wr(scs_pkg::OFS_P, 32'h200);
        // Carry latch is unknown until loaded
        wr(scs_pkg::OFS_STAT, 32'h0);
        wr(scs_pkg::OFS_S, 32'h1);
        wr(scs_pkg::OFS_T, 32'h3FFFF);
        cmd(scs_pkg::CMD_ADD);
        bus(1'b0, scs_pkg::OFS_STAT, 32'h0);
        chk("carry", rd & 32'h3, 32'h3);
        wr(scs_pkg::OFS_S, 32'h1);
        wr(scs_pkg::OFS_T, 32'h1);
        cmd(scs_pkg::CMD_ADD);
        rchk("t", scs_pkg::OFS_T, 32'h3);
        wr(scs_pkg::OFS_P, 32'h000);
        wr(scs_pkg::OFS_T, 32'h20000);
        wr(scs_pkg::OFS_A, 32'h00002);
        cmd(scs_pkg::CMD_MSTEP);
        rchk("t", scs_pkg::OFS_T, 32'h30000);
        rchk("a", scs_pkg::OFS_A, 32'h00001);
        wr(scs_pkg::OFS_S, 32'h5);
        wr(scs_pkg::OFS_T, 32'h0);
        wr(scs_pkg::OFS_A, 32'h1);
        cmd(scs_pkg::CMD_MSTEP);
        rchk("t", scs_pkg::OFS_T, 32'h2);
        rchk("a", scs_pkg::OFS_A, 32'h20000);
    endtask : t_alu

    task t_keep;
        cmd(scs_pkg::CMD_DUP);
        wr(scs_pkg::OFS_T, 32'h11111);
        wr(scs_pkg::OFS_S, 32'h22222);
        wr(scs_pkg::OFS_R, 32'h33333);
        wr(scs_pkg::OFS_A, 32'h04444);
        wr(12'h104, 32'h05555);
        wr(scs_pkg::OFS_P, 32'h200);
        wr(scs_pkg::OFS_IO, 32'h0ABCD);
        wr(scs_pkg::OFS_STAT, 32'h2);
        do_reset();
        rchk("pc", scs_pkg::OFS_P, 32'h0AA);
        rchk("io", scs_pkg::OFS_IO, 32'h15555);
        stat_chk(32'h0);
        rchk("t", scs_pkg::OFS_T, 32'h11111);
        rchk("s", scs_pkg::OFS_S, 32'h22222);
        rchk("r", scs_pkg::OFS_R, 32'h33333);
        rchk("a", scs_pkg::OFS_A, 32'h04444);
        rchk("ram", 12'h104, 32'h05555);
        bus(1'b0, scs_pkg::OFS_STAT, 32'h0);
        chk("carry", rd & 32'h2, 32'h2);
    endtask : t_keep

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        n_mismatch = 0;
        num_checks = 0;
        hresetn    = 1'b1;
        hsel       = 1'b0;
        haddr      = 32'h0;
        htrans     = 2'b00;
        hwrite     = 1'b0;
        hsize      = 3'h2;
        hwdata     = 32'h0;
        @(posedge hclk);
        do_reset();
        t_reset_vals();
        t_fetch();
        t_addr_a();
        t_stacks();
        t_alu();
        t_keep();
        give_verdict();
    end
endmodule : tb_scs_core
`default_nettype wire
